// >>> byte_fifo.sv
/*
 * synchronous byte fifo with valid/ready on both sides and a level count.
 * assumes one clock and a clock enable shared with the caller.
 */
`timescale 1ns/1ps
`default_nettype none
module byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 128
) (
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    input wire logic i_clear,
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [WIDTH-1:0] o_out_data,
    output logic [$clog2(DEPTH):0] o_level
);
    localparam int AW = $clog2(DEPTH);
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
        $error("byte_fifo depth must be a power of two");
    end
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_reg;
    logic [AW:0] rd_reg;
    wire push = i_in_valid && o_in_ready;
    wire pop = o_out_valid && i_out_ready;

    // full when pointers differ only in the wrap bit
    assign o_in_ready = (wr_reg - rd_reg) != (AW+1)'(DEPTH);
    assign o_out_valid = wr_reg != rd_reg;
    assign o_out_data = mem[rd_reg[AW-1:0]];
    assign o_level = wr_reg - rd_reg;

    // pointers; storage array carries no reset
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wr_reg <= '0;
            rd_reg <= '0;
        end else if (i_ce) begin
            wr_reg <= i_clear ? '0 : wr_reg + (AW+1)'(push);
            rd_reg <= i_clear ? '0 : rd_reg + (AW+1)'(pop);
        end
    end
    always_ff @(posedge i_mclk) begin
        if (i_ce && push) begin
            mem[wr_reg[AW-1:0]] <= i_in_data;
        end
    end
endmodule : byte_fifo
`default_nettype wire

// >>> fifo_host_model.sv
/*
 * behavioural external logic host for the parallel fifo port.
 * assumes the bench resolves the data pins from the device data enable and runs 50 MHz.
 */
`timescale 1ns/1ps
`default_nettype none
module fifo_host_model (
    input wire logic i_mclk,
    input wire logic [7:0] i_pins,
    input wire logic i_rx_data_avail_n,
    input wire logic i_tx_space_avail_n,
    output logic o_read_strobe_n,
    output logic o_write_strobe,
    output logic [7:0] o_data,
    output logic o_wake_n
);
    // idle host: strobes inactive, wake line at its pull-up level
    initial begin
        o_read_strobe_n = 1'b1;
        o_write_strobe = 1'b0;
        o_data = 8'h00;
        o_wake_n = 1'b1;
    end

    // one read cycle, ok low when no byte is flagged within 100 cycles
    task automatic rd(output logic [7:0] b, output logic ok);
        int n;
        ok = 1'b0;
        for (n = 0; n < 100 && !ok; n++) begin
            @(negedge i_mclk);
            ok = (i_rx_data_avail_n === 1'b0);
        end
        b = 8'h00;
        if (ok) begin
            @(posedge i_mclk);
            // strobe low 100 ns, margin for the pin synchroniser
            o_read_strobe_n <= 1'b0;
            repeat (5) @(posedge i_mclk);
            b = i_pins;
            o_read_strobe_n <= 1'b1;
            // precharge of 50 ns plus the 80 ns flag gap
            repeat (7) @(posedge i_mclk);
        end
    endtask : rd

    // one write cycle, waits for space first
    task automatic wr(input logic [7:0] b);
        int n;
        // wait up to 100 cycles for space, then write regardless
        for (n = 0; n < 100; n++) begin
            @(negedge i_mclk);
            if (i_tx_space_avail_n === 1'b0) break;
        end
        @(posedge i_mclk);
        // strobe active 60 ns with data set up
        o_data <= b;
        o_write_strobe <= 1'b1;
        repeat (3) @(posedge i_mclk);
        o_write_strobe <= 1'b0;
        repeat (3) @(posedge i_mclk);
        // a released bus must not keep showing the byte
        o_data <= ~b;
        repeat (3) @(posedge i_mclk);
    endtask : wr

    // hold the wake line low for the given cycles
    task automatic wake(input int cyc);
        @(posedge i_mclk);
        o_wake_n <= 1'b0;
        repeat (cyc) @(posedge i_mclk);
        o_wake_n <= 1'b1;
    endtask : wake
endmodule : fifo_host_model
`default_nettype wire

// >>> fifo_port.sv
/*
 * parallel fifo port: receive and transmit buffers, strobe handshake, bit-bang
 * modes, flush timer and suspend wake input, with an apb register slave.
 * assumes strobes and data pins arrive asynchronously and that the usb side
 * is modelled by software through the data registers.
 */
// Chosen here: the APB register port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "fifo_port_defines.svh"
module fifo_port
    import fifo_port_pkg::*;
#(
    parameter int RX_DEPTH = 128,
    parameter int TX_DEPTH = 256,
    parameter int MS_CYCLES = `MS_CYC
) (
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic [7:0] i_data,
    output logic [7:0] o_data,
    output logic o_data_oe_n,
    input wire logic i_read_strobe_n,
    input wire logic i_write_strobe,
    input wire logic i_rx_data_avail_n,
    output logic o_rx_data_avail_n,
    output logic o_rx_data_avail_oe_n,
    output logic o_tx_space_avail_n,
    output logic o_resume_req,
    output logic o_flush_pulse
);
    if (RX_DEPTH < 2 || TX_DEPTH < 2 || MS_CYCLES < 1) begin : g_bad_param
        $error("bad buffer depth or ms count");
    end
    localparam int GAP = `FLAG_GAP_CYC;
    localparam int RL = $clog2(RX_DEPTH);
    localparam int TL = $clog2(TX_DEPTH);

    // [R11] pins cross into the single core clock
    logic [10:0] pin_s;
    // write strobe idles low, so its flops reset low too: no false capture after reset
    pin_sync #(.WIDTH(11), .RESET_VAL(11'h5ff)) u_sync (
        .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_ce(i_ce),
        .i_async({i_rx_data_avail_n, i_write_strobe, i_read_strobe_n, i_data}),
        .o_sync(pin_s)
    );
    wire [7:0] data_s = pin_s[7:0];
    wire rd_n_s = pin_s[8];
    wire wr_s = pin_s[9];
    wire wake_s = pin_s[10];

    logic rd_n_d_reg, wr_d_reg;
    wire rd_fall = rd_n_d_reg && !rd_n_s;
    wire rd_rise = !rd_n_d_reg && rd_n_s;
    wire wr_fall = wr_d_reg && !wr_s;

    // registers
    logic [31:0] ctrl_reg;
    logic [7:0] flush_ms_reg;
    logic [15:0] bbdiv_reg;
    logic [7:0] sample_reg;
    logic sample_vld_reg;
    wire [1:0] mode_raw = ctrl_reg[`CTRL_MODE_LSB +: 2];
    wire port_mode_e mode = (mode_raw == 2'b11) ? MODE_FIFO : port_mode_e'(mode_raw);
    wire suspend = ctrl_reg[`CTRL_SUSPEND];
    wire wake_en = ctrl_reg[`CTRL_WAKE_EN];

    function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
        return a == off;
    endfunction
    wire acc = i_psel && i_penable;
    wire wr_acc = acc && i_pwrite;
    wire rd_acc = acc && !i_pwrite;
    wire mapped = hit(i_paddr, `OFF_CTRL) || hit(i_paddr, `OFF_FLUSH) || hit(i_paddr, `OFF_STATUS)
        || hit(i_paddr, `OFF_RXDATA) || hit(i_paddr, `OFF_TXDATA) || hit(i_paddr, `OFF_BBDIV)
        || hit(i_paddr, `OFF_SAMPLE);

    // [R12] receive buffer: software plays the out endpoint
    logic rx_in_rdy, rx_vld, rx_pop;
    logic [7:0] rx_byte;
    logic [RL:0] rx_lvl;
    byte_fifo #(.WIDTH(8), .DEPTH(RX_DEPTH)) u_rx (
        .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_ce(i_ce), .i_clear(1'b0),
        .i_in_valid(wr_acc && hit(i_paddr, `OFF_RXDATA)), .o_in_ready(rx_in_rdy),
        .i_in_data(i_pwdata[7:0]), .o_out_valid(rx_vld), .i_out_ready(rx_pop),
        .o_out_data(rx_byte), .o_level(rx_lvl)
    );
    // [R13] transmit buffer: software plays the in endpoint
    logic tx_push, tx_rdy, tx_vld;
    logic [7:0] tx_byte, tx_in;
    logic [TL:0] tx_lvl;
    wire tx_pop = rd_acc && hit(i_paddr, `OFF_TXDATA);
    byte_fifo #(.WIDTH(8), .DEPTH(TX_DEPTH)) u_tx (
        .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_ce(i_ce), .i_clear(1'b0),
        .i_in_valid(tx_push), .o_in_ready(tx_rdy),
        .i_in_data(tx_in), .o_out_valid(tx_vld), .i_out_ready(tx_pop),
        .o_out_data(tx_byte), .o_level(tx_lvl)
    );

    // read-side and write-side guard timers after each strobe cycle
    logic [3:0] rx_gap_reg, tx_gap_reg;
    logic rd_active_reg;
    logic [7:0] out_reg;
    logic [15:0] bb_cnt_reg;
    wire bb_tick = (mode == MODE_ABB) && rx_vld && (bb_cnt_reg == '0);
    wire fifo_mode = (mode == MODE_FIFO);
    // [R19] byte is popped on read strobe fall in fifo mode
    // [R7] async bit-bang pops a byte on each timer tick
    // the flag is already high once the strobe is low, so only buffer state gates the pop
    assign rx_pop = (fifo_mode && rd_fall && rx_vld) || bb_tick
        || (mode == MODE_SBB && rx_vld && tx_rdy);
    // [R20] write strobe fall captures the pin byte; bit-bang sync stores samples
    assign tx_push = (fifo_mode && wr_fall && tx_rdy) || (mode == MODE_SBB && rx_vld && tx_rdy);
    // [R14] pin byte feeds the transmit buffer
    // [R8] sync mode returns the pin state seen as the new byte is written
    assign tx_in = fifo_mode ? data_s : data_s;

    // [R16] every register below takes its reset value on the asynchronous reset
    // edge history, read data latch and guard timers
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rd_n_d_reg <= 1'b1;
            wr_d_reg <= 1'b0;
            rd_active_reg <= 1'b0;
            out_reg <= 8'h00;
            rx_gap_reg <= 4'h0;
            tx_gap_reg <= 4'h0;
            bb_cnt_reg <= 16'h0000;
        end else if (i_ce) begin
            rd_n_d_reg <= rd_n_s;
            wr_d_reg <= wr_s;
            if (fifo_mode && rd_fall) begin
                rd_active_reg <= 1'b1;
            end else if (rd_rise || !fifo_mode) begin
                rd_active_reg <= 1'b0;
            end
            if (rx_pop) begin
                out_reg <= rx_byte;
            end
            // [R3] flag held inactive for the gap after each read
            if (fifo_mode && (rd_fall || !rd_n_s)) begin
                rx_gap_reg <= 4'(GAP);
            end else if (rx_gap_reg != 4'h0) begin
                rx_gap_reg <= rx_gap_reg - 4'h1;
            end
            // [R6] flag held inactive for the gap after each write
            if (fifo_mode && (wr_fall || wr_s)) begin
                tx_gap_reg <= 4'(GAP);
            end else if (tx_gap_reg != 4'h0) begin
                tx_gap_reg <= tx_gap_reg - 4'h1;
            end
            if (mode != MODE_ABB || bb_cnt_reg == '0) begin
                bb_cnt_reg <= (rx_vld && mode == MODE_ABB) ? bbdiv_reg : 16'h0000;
            end else begin
                bb_cnt_reg <= bb_cnt_reg - 16'h1;
            end
        end
    end

    // [R17] data flag low only with unread data and gap elapsed
    wire rx_flag_n = !(fifo_mode && rx_vld && rx_gap_reg == 4'h0 && rd_n_s);
    // [R18] space flag low only with room and gap elapsed
    wire tx_flag_n = !(fifo_mode && tx_rdy && tx_gap_reg == 4'h0 && !wr_s);
    wire wake_mode = suspend && wake_en;
    assign o_rx_data_avail_n = rx_flag_n;
    // [R10] flag pin becomes an input during suspend with wake enabled
    assign o_rx_data_avail_oe_n = wake_mode;
    assign o_tx_space_avail_n = tx_flag_n;
    // [R21] pins driven only during a read, or always in bit-bang modes
    assign o_data_oe_n = fifo_mode ? !(rd_active_reg && !rd_n_s) : 1'b0;
    assign o_data = out_reg;

    // [R10] wake low time counter
    logic [31:0] wake_cnt_reg;
    logic resume_reg;
    wire [31:0] wake_lim = 32'(`WAKE_MS * MS_CYCLES);
    wire wake_done = wake_cnt_reg >= wake_lim;
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wake_cnt_reg <= 32'h0;
            resume_reg <= 1'b0;
        end else if (i_ce) begin
            wake_cnt_reg <= (wake_mode && !wake_s && !wake_done) ? wake_cnt_reg + 32'h1
                : (wake_mode && !wake_s) ? wake_cnt_reg : 32'h0;
            // fire as the count reaches the limit, so a long low gives one pulse
            resume_reg <= wake_mode && !wake_s && wake_cnt_reg == wake_lim - 32'h1;
            if (!wake_mode) begin
                resume_reg <= 1'b0;
            end
        end
    end
    assign o_resume_req = resume_reg;

    // [R9] flush timer restarts on each transmit byte, fires on partial data
    logic [31:0] flush_cnt_reg;
    logic flush_reg;
    wire [31:0] flush_lim = 32'(flush_ms_reg) * 32'(MS_CYCLES);
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            flush_cnt_reg <= 32'h0;
            flush_reg <= 1'b0;
        end else if (i_ce) begin
            flush_reg <= 1'b0;
            if (tx_push || !tx_vld) begin
                flush_cnt_reg <= 32'h0;
            end else if (flush_cnt_reg + 32'h1 >= flush_lim) begin
                flush_cnt_reg <= 32'h0;
                flush_reg <= 1'b1;
            end else begin
                flush_cnt_reg <= flush_cnt_reg + 32'h1;
            end
        end
    end
    assign o_flush_pulse = flush_reg;

    // [R15] apb register writes set mode, wake, suspend, timeout and rate
    wire [7:0] flush_wr = (i_pwdata[7:0] < `FLUSH_MIN_MS) ? `FLUSH_MIN_MS : i_pwdata[7:0];
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ctrl_reg <= `CTRL_RESET;
            flush_ms_reg <= `FLUSH_DEF_MS;
            bbdiv_reg <= `BBDIV_RESET;
            sample_reg <= 8'h00;
            sample_vld_reg <= 1'b0;
        end else if (i_ce) begin
            if (wr_acc && hit(i_paddr, `OFF_CTRL)) begin
                ctrl_reg <= {28'h0, i_pwdata[3:0]};
            end
            if (wr_acc && hit(i_paddr, `OFF_FLUSH)) begin
                flush_ms_reg <= flush_wr;
            end
            if (wr_acc && hit(i_paddr, `OFF_BBDIV)) begin
                bbdiv_reg <= i_pwdata[15:0];
            end
            // async mode samples pins continuously, sync mode only per written byte
            if (mode == MODE_ABB || (mode == MODE_SBB && tx_push)) begin
                sample_reg <= data_s;
            end
            // a new sample wins over the clear by read
            if (mode == MODE_SBB && tx_push) begin
                sample_vld_reg <= 1'b1;
            end else if (rd_acc && hit(i_paddr, `OFF_SAMPLE)) begin
                sample_vld_reg <= 1'b0;
            end
        end
    end

    // read mux; unmapped addresses answer with an error and zero data
    always_comb begin
        o_prdata = 32'h0;
        if (hit(i_paddr, `OFF_CTRL)) o_prdata = ctrl_reg;
        if (hit(i_paddr, `OFF_FLUSH)) o_prdata = {24'h0, flush_ms_reg};
        if (hit(i_paddr, `OFF_STATUS)) o_prdata = {8'(tx_lvl), 8'(rx_lvl), 12'h0, resume_reg,
            sample_vld_reg, tx_vld, rx_vld};
        if (hit(i_paddr, `OFF_TXDATA)) o_prdata = {23'h0, tx_vld, tx_byte};
        if (hit(i_paddr, `OFF_BBDIV)) o_prdata = {16'h0, bbdiv_reg};
        if (hit(i_paddr, `OFF_SAMPLE)) o_prdata = {24'h0, sample_reg};
    end
    assign o_pready = 1'b1;
    assign o_pslverr = acc && (!mapped || (i_pwrite && hit(i_paddr, `OFF_RXDATA) && !rx_in_rdy));

    // [R3] data flag stays high for the gap after the strobe rises
    rx_gap_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        i_ce && rd_rise && fifo_mode |=> o_rx_data_avail_n [*3]) else $error("rx flag fell too soon");
    // [R6] space flag stays high for the gap after the strobe falls
    tx_gap_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        i_ce && wr_fall && fifo_mode |=> o_tx_space_avail_n [*3]) else $error("tx flag fell too soon");
    // [R17] data flag low only with data present
    rx_flag_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        !o_rx_data_avail_n |-> rx_vld) else $error("rx flag low while empty");
    // [R18] space flag low only with room
    tx_flag_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        !o_tx_space_avail_n |-> tx_rdy) else $error("tx flag low while full");
    // [R21] pins released outside a read in fifo mode
    pin_drive_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        fifo_mode && rd_n_s |-> o_data_oe_n) else $error("pins driven without read");
    // [R19] fetched byte appears on the pins next cycle
    rd_fetch_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        i_ce && rx_pop |=> o_data == $past(rx_byte)) else $error("read byte not presented");
    // [R10] wake request only in suspend with wake enabled
    wake_req_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        o_resume_req |-> $past(wake_mode) && !$past(wake_s)) else $error("resume without wake");
    // [R9] flush pulse only with pending transmit data
    flush_tmo_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        o_flush_pulse |-> $past(tx_vld)) else $error("flush with empty buffer");
    // [R15] timeout never below the minimum
    flush_min_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        flush_ms_reg >= `FLUSH_MIN_MS) else $error("flush timeout below minimum");
    // [R20] a captured write byte raises the transmit level by one
    wr_capture_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        i_ce && fifo_mode && wr_fall && tx_rdy && !tx_pop |=> tx_lvl == $past(tx_lvl) + 1'b1)
        else $error("write byte not captured");
    // [R10] no second resume pulse within 8 cycles of one
    wake_once_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        o_resume_req |=> !o_resume_req [*8]) else $error("resume repeated");
endmodule : fifo_port
`default_nettype wire

// >>> fifo_port_bench.sv
/*
 * self-checking bench for the parallel fifo port: apb master, host model.
 * assumes ms counts shortened to 10 cycles; the apb master waits for pready.
 */
`timescale 1ns/1ps
`default_nettype none
`include "fifo_port_defines.svh"
module fifo_port_bench;
    import fifo_port_pkg::*;
    localparam int MS = 10;
    logic mclk, rst_n, psel, penable, pwrite, pready, pslverr, rs_n, ws, wake_n;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic [7:0] dout, hdata;
    logic oe_n, rxf_n, rxf_oe_n, txe_n, resume, flush, e, ok, ce;
    int num_errors = 0, n_checks = 0, cycles = 0;
    // pins: device wins while enabled, else host
    wire logic [7:0] pins = (oe_n === 1'b0) ? dout : hdata;
    wire logic flag_in = (rxf_oe_n === 1'b0) ? rxf_n : wake_n;

    fifo_port #(.MS_CYCLES(MS)) i_fifo_port (.i_mclk(mclk), .i_rst_n(rst_n), .i_ce(ce),
        .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
        .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_data(pins), .o_data(dout),
        .o_data_oe_n(oe_n), .i_read_strobe_n(rs_n), .i_write_strobe(ws), .i_rx_data_avail_n(flag_in),
        .o_rx_data_avail_n(rxf_n), .o_rx_data_avail_oe_n(rxf_oe_n), .o_tx_space_avail_n(txe_n),
        .o_resume_req(resume), .o_flush_pulse(flush));
    fifo_host_model i_fifo_host_model (.i_mclk(mclk), .i_pins(pins), .i_rx_data_avail_n(rxf_n),
        .i_tx_space_avail_n(txe_n), .o_read_strobe_n(rs_n), .o_write_strobe(ws), .o_data(hdata),
        .o_wake_n(wake_n));

    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    task automatic stop_test();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : stop_test

    // hang guard well above the run length
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            num_errors++;
            stop_test();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // one apb transfer; answer taken at the rising edge that sees pready high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1) @(posedge mclk);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic t_reset();
        apb(1'b0, `OFF_CTRL, 32'h0); chk(r, 32'h4);
        apb(1'b0, `OFF_FLUSH, 32'h0); chk(r, 32'h10);
        apb(1'b0, `OFF_BBDIV, 32'h0); chk(r, 32'h32);
        // a write while the clock enable is low must leave no trace
        ce <= 1'b0;
        apb(1'b1, `OFF_FLUSH, 32'h20);
        ce <= 1'b1;
        apb(1'b0, `OFF_FLUSH, 32'h0); chk(r, 32'h10);
        apb(1'b0, `OFF_STATUS, 32'h0); chk(r, 32'h0);
        chk({rxf_n, txe_n, oe_n}, 3'b101);
        apb(1'b0, 12'h0fc, 32'h0); chk({e, r}, {1'b1, 32'h0});
    endtask : t_reset

    task automatic t_rx();
        logic [7:0] b;
        apb(1'b1, `OFF_RXDATA, 32'h5a);
        apb(1'b1, `OFF_RXDATA, 32'ha5);
        apb(1'b0, `OFF_STATUS, 32'h0); chk(r, 32'h0002_0001);
        // flag must stay high for 80 ns after the strobe rises
        fork
            i_fifo_host_model.rd(b, ok);
            begin
                @(posedge rs_n);
                repeat (4) begin
                    @(negedge mclk) chk(rxf_n, 1'b1);
                end
            end
        join
        chk({ok, b}, 9'h15a);
        i_fifo_host_model.rd(b, ok); chk({ok, b}, 9'h1a5);
        @(negedge mclk); chk({rxf_n, oe_n}, 2'b11);
        i_fifo_host_model.rd(b, ok); chk(ok, 1'b0);
    endtask : t_rx

    task automatic t_tx();
        i_fifo_host_model.wr(8'h3c);
        i_fifo_host_model.wr(8'hc3);
        apb(1'b0, `OFF_STATUS, 32'h0); chk(r, 32'h0200_0002);
        apb(1'b0, `OFF_TXDATA, 32'h0); chk(r, 32'h13c);
        apb(1'b0, `OFF_TXDATA, 32'h0); chk(r, 32'h1c3);
        @(negedge mclk); chk(txe_n, 1'b0);
    endtask : t_tx

    task automatic t_full();
        for (int i = 0; i < 128; i++) apb(1'b1, `OFF_RXDATA, i);
        chk(e, 1'b0);
        apb(1'b1, `OFF_RXDATA, 32'h77); chk(e, 1'b1);
        // mid-run reset empties everything
        @(posedge mclk) rst_n <= 1'b0;
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        apb(1'b0, `OFF_STATUS, 32'h0); chk(r, 32'h0);
    endtask : t_full

    task automatic t_flush();
        int n;
        apb(1'b1, `OFF_FLUSH, 32'h1);
        apb(1'b0, `OFF_FLUSH, 32'h0); chk(r, 32'h2);
        i_fifo_host_model.wr(8'h11);
        for (n = 0; n < 60 && flush !== 1'b1; n++) @(negedge mclk);
        // about two ms since the push, part of it spent inside the write task
        chk(n >= 2 * MS - 12 && n <= 2 * MS + 6, 1'b1);
        apb(1'b0, `OFF_TXDATA, 32'h0); chk(r, 32'h111);
    endtask : t_flush

    task automatic t_wake();
        int hit;
        hit = 0;
        apb(1'b1, `OFF_CTRL, 32'hc);
        @(negedge mclk); chk(rxf_oe_n, 1'b1);
        fork
            i_fifo_host_model.wake(20 * MS + 20);
            for (int i = 0; i < 20 * MS + 20; i++) begin
                @(negedge mclk);
                if (resume === 1'b1) begin
                    chk(i >= 20 * MS, 1'b1);
                    hit++;
                end
            end
        join
        chk(hit, 1);
        apb(1'b1, `OFF_CTRL, 32'h4);
    endtask : t_wake

    task automatic t_bitbang();
        apb(1'b1, `OFF_BBDIV, 32'h4);
        apb(1'b1, `OFF_CTRL, {29'h0, 1'b1, MODE_ABB});
        apb(1'b1, `OFF_RXDATA, 32'h96);
        apb(1'b1, `OFF_RXDATA, 32'h69);
        repeat (30) @(posedge mclk);
        @(negedge mclk); chk({oe_n, dout}, 9'h069);
        apb(1'b1, `OFF_CTRL, {29'h0, 1'b1, MODE_SBB});
        apb(1'b1, `OFF_RXDATA, 32'h81);
        repeat (20) @(posedge mclk);
        @(negedge mclk); chk({oe_n, dout}, 9'h081);
        // the sample is taken as the byte lands, so it shows the byte driven before it
        apb(1'b0, `OFF_STATUS, 32'h0); chk(r[2], 1'b1);
        apb(1'b0, `OFF_SAMPLE, 32'h0); chk(r, 32'h69);
        apb(1'b0, `OFF_TXDATA, 32'h0); chk(r, 32'h169);
        apb(1'b0, `OFF_TXDATA, 32'h0); chk(r[8], 1'b0);
        apb(1'b1, `OFF_CTRL, 32'h4);
    endtask : t_bitbang

    // main sequence
    initial begin
        rst_n = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        ce = 1'b1;
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        t_reset();
        t_rx();
        t_tx();
        t_full();
        t_flush();
        t_wake();
        t_bitbang();
        stop_test();
    end
endmodule : fifo_port_bench
`default_nettype wire

// >>> fifo_port_defines.svh
/*
 * constants for the parallel fifo port: register offsets, field positions,
 * reset values and timing counts. assumes a 50 MHz core clock.
 */
// Overview of operation
// [R1] host holds read strobe low at least 50 ns per read.
// [R2] host keeps read strobe high 50 ns plus flag-inactive time between reads.
// [R3] data-available flag stays high at least 80 ns after each read.
// [R4] host holds write strobe active at least 50 ns per write.
// [R5] host keeps write strobe inactive at least 50 ns between writes.
// [R6] space-available flag stays high at least 80 ns after each write.
// [R7] async bit-bang drives received bytes onto pins, paced by a timer.
// [R8] sync bit-bang samples pins only when a new output byte is written.
// [R9] flush partial transmit data on timer expiry; 16 ms default, 2 to 255 ms.
// [R10] in suspend with wake enabled, 20 ms low on flag pin requests resume.
// [R11] fifo controller runs from the single core clock.
// [R12] 128-byte receive buffer fed by out endpoint, one byte per read.
// [R13] 256-byte transmit buffer drained by in endpoint requests.
// [R14] controller moves bytes between both buffers and the data pins.
// [R15] software sets flush timeout and bit-bang mode through registers.
// [R16] asynchronous active-low reset restarts everything.
// [R17] data-available low only while unread data exists.
// [R18] space-available low only while a byte can be accepted.
// [R19] read strobe falling edge fetches next byte, driven while strobe low.
// [R20] write strobe falling edge captures pin byte into transmit buffer.
// [R21] data pins driven only while read strobe low in fifo mode.
`ifndef FIFO_PORT_DEFINES_SVH
`define FIFO_PORT_DEFINES_SVH

`define CLK_HZ 50000000
`define FLAG_GAP_NS 80
`define FLAG_GAP_CYC ((`FLAG_GAP_NS * (`CLK_HZ / 1000000) + 999) / 1000)
`define MS_CYC (`CLK_HZ / 1000)
`define WAKE_MS 20
`define FLUSH_DEF_MS 8'h10
`define FLUSH_MIN_MS 8'h02

`define OFF_CTRL 12'h000
`define OFF_FLUSH 12'h004
`define OFF_STATUS 12'h008
`define OFF_RXDATA 12'h00c
`define OFF_TXDATA 12'h010
`define OFF_BBDIV 12'h014
`define OFF_SAMPLE 12'h018

`define CTRL_MODE_LSB 0
`define CTRL_WAKE_EN 2
`define CTRL_SUSPEND 3
`define CTRL_RESET 32'h0000_0004
`define BBDIV_RESET 16'h0032

`endif

// >>> fifo_port_pkg.sv
/*
 * types for the parallel fifo port. assumes fifo_port_defines.svh beside it.
 */
package fifo_port_pkg;
    typedef enum logic [1:0] {
        MODE_FIFO = 2'b00,
        MODE_ABB = 2'b01,
        MODE_SBB = 2'b10
    } port_mode_e;
endpackage : fifo_port_pkg

// >>> pin_sync.sv
/*
 * two-flop synchroniser for a bus of pin inputs. assumes asynchronous pins.
 */
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
    parameter int WIDTH = 10,
    // flop level during reset; each bit should match its pin's idle level
    parameter logic [WIDTH-1:0] RESET_VAL = '1
) (
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] meta_reg;
    // first stage feeds only the second stage
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            meta_reg <= RESET_VAL;
            o_sync <= RESET_VAL;
        end else if (i_ce) begin
            meta_reg <= i_async;
            o_sync <= meta_reg;
        end
    end
endmodule : pin_sync
`default_nettype wire
